// file: include/pwm_pkg.sv
package pwm_pkg;

  // Register byte addresses on the bus.
  localparam logic [7:0] ADDR_DUTY_A = 8'h00;
  localparam logic [7:0] ADDR_DUTY_B = 8'h04;
  localparam logic [7:0] ADDR_DUTY_C = 8'h08;
  localparam logic [7:0] ADDR_HALF_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_DEAD_TIME = 8'h10;
  localparam logic [7:0] ADDR_MIN_PULSE = 8'h14;
  localparam logic [7:0] ADDR_SYNC_WIDTH = 8'h18;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // Field widths, positions and reset values.
  localparam int unsigned DEAD_W = 10;
  localparam int unsigned SYNC_W = 8;
  localparam int unsigned MODE_DOUBLE_BIT = 6;
  localparam int unsigned STATUS_ARMED_BIT = 0;
  localparam int unsigned STATUS_RUN_BIT = 1;
  localparam int unsigned STATUS_HALF_BIT = 3;
  localparam logic [15:0] ZERO_16 = 16'h0000;
  localparam logic [15:0] ONE_16 = 16'h0001;
  localparam logic [7:0] SYNC_WIDTH_RESET = 8'h27;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // Indices of the written-once flags.
  localparam int unsigned WR_HALF = 0;
  localparam int unsigned WR_A = 1;
  localparam int unsigned WR_B = 2;
  localparam int unsigned WR_C = 3;

  // One complete set of timing values, latched together at a sync edge.
  typedef struct packed {
    logic [15:0] half;
    logic [DEAD_W-1:0] dead;
    logic [15:0] minw;
    logic [SYNC_W-1:0] sync_w;
    logic dbl;
  } timing_set_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } timer_state_type;

endpackage

// file: hw/pwm_pair.sv
`timescale 1ns/100ps
module pwm_pair
  import pwm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Timer position and latched values.
  input wire logic enable_i,
  input wire logic second_half_i,
  input wire logic [15:0] count_i,
  input wire logic [15:0] duty_i,
  input wire timing_set_type set_i,
  // Active-low switch commands.
  output logic high_n_o,
  output logic low_n_o
);

  // Clamps a signed on-time into 0 .. half period.
  function automatic logic [15:0] clamp(input logic signed [17:0] raw, input logic [15:0] lim);
    if (raw < 18'sh00000) return ZERO_16;
    else if (raw > $signed({2'b00, lim})) return lim;
    else return raw[15:0];
  endfunction

  logic signed [17:0] hi_raw;
  logic signed [17:0] lo_raw;
  logic [15:0] hi_cl;
  logic [15:0] lo_cl;
  logic hi_short;
  logic lo_short;
  logic [15:0] hi_on;
  logic [15:0] lo_on;
  logic hi_act;
  logic lo_act;

  // Per-half on-times after dead time; each edge moves by the dead count.
  assign hi_raw = $signed({2'b00, duty_i}) - $signed({8'h00, set_i.dead});
  assign lo_raw = $signed({2'b00, set_i.half}) - $signed({2'b00, duty_i})
                  - $signed({8'h00, set_i.dead});
  assign hi_cl = clamp(hi_raw, set_i.half);
  assign lo_cl = clamp(lo_raw, set_i.half);

  // Short pulses are dropped and the partner held on for the whole half.
  assign hi_short = hi_cl < set_i.minw;
  assign lo_short = lo_cl < set_i.minw;
  assign hi_on = hi_short ? ZERO_16 : (lo_short ? set_i.half : hi_cl);
  assign lo_on = hi_short ? set_i.half : (lo_short ? ZERO_16 : lo_cl);

  // High side sits around the period midpoint, low side around its ends.
  assign hi_act = second_half_i ? (count_i < hi_on) : (count_i >= set_i.half - hi_on);
  assign lo_act = second_half_i ? (count_i >= set_i.half - lo_on) : (count_i < lo_on);

  // Outputs are registered so the gate drivers never see decode glitches.
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      high_n_o <= 1'b1;
      low_n_o <= 1'b1;
    end else begin
      high_n_o <= ~hi_act;
      low_n_o <= ~lo_act;
    end
  end

  property p_clamp;
    @(posedge clk_i) disable iff (rst_i)
      (hi_on <= set_i.half) && (lo_on <= set_i.half);
  endproperty
  a_clamp: assert property (p_clamp) else $error("on-time beyond half period");

  property p_min_pulse;
    @(posedge clk_i) disable iff (rst_i)
      enable_i && hi_short |=> high_n_o && ($past(lo_act) == !low_n_o) && $past(lo_on == set_i.half);
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("short pulse not suppressed");

  property p_dead_gap;
    @(posedge clk_i) disable iff (rst_i)
      (set_i.dead != '0) && (set_i.minw == ZERO_16) |=> !(!high_n_o && !low_n_o);
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("both switches on");

endmodule // pwm_pair

// file: hw/pwm_timing_unit.sv
`timescale 1ns/100ps
module pwm_timing_unit
  import pwm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Inverter gate commands, active low.
  output logic phase_a_high_out_n_o,
  output logic phase_a_low_out_n_o,
  output logic phase_b_high_out_n_o,
  output logic phase_b_low_out_n_o,
  output logic phase_c_high_out_n_o,
  output logic phase_c_low_out_n_o,
  // Update marker: each period start, and also each midpoint in double update.
  output logic cycle_sync_pulse_o
);

  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) res[7:0] = wd[7:0];
    if (sel[1]) res[15:8] = wd[15:8];
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake.

  logic ack_r;
  logic [31:0] dat_r;
  logic req_w;
  logic wr_fire;

  assign req_w = cyc_i && stb_i;
  // Writes land at the edge where ack is seen, matching the master's commit point.
  assign wr_fire = req_w && we_i && ack_r;
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // Ack rises one cycle after the request and drops the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_r <= 1'b0;
    else ack_r <= req_w && !ack_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers.

  logic [2:0][15:0] duty_r;
  logic [15:0] half_period_count_r;
  logic [DEAD_W-1:0] dead_time_count_r;
  logic [15:0] min_pulse_width_r;
  logic [SYNC_W-1:0] sync_pulse_width_r;
  logic [15:0] mode_control_reg_r;
  logic [3:0] written_r;
  logic wr_half;
  logic [15:0] half_nxt;
  logic [15:0] dead_nxt;
  logic double_w;
  logic [2:0] wr_duty;

  assign wr_half = wr_fire && (adr_i == ADDR_HALF_PERIOD);
  assign half_nxt = merge16(half_period_count_r, dat_i, sel_i);
  assign dead_nxt = merge16({6'h00, dead_time_count_r}, dat_i, sel_i);
  assign double_w = mode_control_reg_r[MODE_DOUBLE_BIT];
  assign wr_duty[0] = wr_fire && (adr_i == ADDR_DUTY_A);
  assign wr_duty[1] = wr_fire && (adr_i == ADDR_DUTY_B);
  assign wr_duty[2] = wr_fire && (adr_i == ADDR_DUTY_C);

  // Duty registers are identical per phase.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_duty
      always_ff @(posedge clk_i) begin
        if (rst_i) duty_r[gi] <= ZERO_16;
        else if (wr_duty[gi]) duty_r[gi] <= merge16(duty_r[gi], dat_i, sel_i);
      end
    end
  endgenerate

  // Configuration registers and written-once tracking.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_period_count_r <= ZERO_16;
      dead_time_count_r <= '0;
      min_pulse_width_r <= ZERO_16;
      sync_pulse_width_r <= SYNC_WIDTH_RESET;
      mode_control_reg_r <= MODE_RESET;
      written_r <= 4'h0;
    end else if (wr_fire) begin
      unique case (adr_i)
        ADDR_HALF_PERIOD: half_period_count_r <= half_nxt;
        ADDR_DEAD_TIME: dead_time_count_r <= dead_nxt[DEAD_W-1:0];
        ADDR_MIN_PULSE: min_pulse_width_r <= merge16(min_pulse_width_r, dat_i, sel_i);
        ADDR_SYNC_WIDTH: if (sel_i[0]) sync_pulse_width_r <= dat_i[SYNC_W-1:0];
        ADDR_MODE_CTRL: mode_control_reg_r <= merge16(mode_control_reg_r, dat_i, sel_i);
        default: ;
      endcase
      if (wr_half) written_r[WR_HALF] <= 1'b1;
      if (wr_duty[0]) written_r[WR_A] <= 1'b1;
      if (wr_duty[1]) written_r[WR_B] <= 1'b1;
      if (wr_duty[2]) written_r[WR_C] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main timer.

  timer_state_type state_r;
  timing_set_type act_r;
  timing_set_type shadow_w;
  logic [2:0][15:0] duty_act_r;
  logic [15:0] cnt_r;
  logic half_r;
  logic armed_w;
  logic outputs_on_w;
  logic terminal_w;
  logic sync_evt_w;

  assign shadow_w = '{half: half_period_count_r, dead: dead_time_count_r,
                      minw: min_pulse_width_r, sync_w: sync_pulse_width_r, dbl: double_w};
  assign armed_w = &written_r;
  assign outputs_on_w = armed_w && (state_r == ST_RUN);
  assign terminal_w = (act_r.half <= ONE_16) || (cnt_r >= act_r.half - ONE_16);
  // A new period always syncs; the midpoint syncs only in double update.
  assign sync_evt_w = (state_r == ST_RUN) && !wr_half && terminal_w
                      && (half_r || double_w);

  // Counter and half flag; a half-period write restarts the timer so that
  // the first sync falls 1.5 halves later in single, one half in double.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= ZERO_16;
      half_r <= 1'b0;
    end else if (wr_half) begin
      state_r <= ST_RUN;
      cnt_r <= double_w ? ZERO_16 : {1'b0, half_nxt[15:1]};
      half_r <= double_w;
    end else begin
      unique case (state_r)
        ST_IDLE: cnt_r <= ZERO_16;
        ST_RUN: begin
          if (terminal_w) begin
            cnt_r <= ZERO_16;
            half_r <= ~half_r;
          end else begin
            cnt_r <= cnt_r + ONE_16;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Working copies; in single update the midpoint keeps the first half's
  // values, which is what makes the two halves mirror each other.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_r <= '0;
      duty_act_r <= '0;
    end else if (wr_half) begin
      act_r <= shadow_w;
      act_r.half <= half_nxt;
    end else if (sync_evt_w) begin
      act_r <= shadow_w;
      duty_act_r <= duty_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sync pulse, sync width plus one clocks long.

  logic sync_r;
  logic [SYNC_W-1:0] sync_cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 1'b0;
      sync_cnt_r <= '0;
    end else if (sync_evt_w) begin
      sync_r <= 1'b1;
      sync_cnt_r <= sync_pulse_width_r;
    end else if (sync_cnt_r != '0) begin
      sync_cnt_r <= sync_cnt_r - 8'h01;
    end else begin
      sync_r <= 1'b0;
    end
  end

  assign cycle_sync_pulse_o = sync_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Output pairs.

  logic [2:0] high_n_w;
  logic [2:0] low_n_w;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_pair
      pwm_pair u_pair (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(outputs_on_w),
        .second_half_i(half_r),
        .count_i(cnt_r),
        .duty_i(duty_act_r[gi]),
        .set_i(act_r),
        .high_n_o(high_n_w[gi]),
        .low_n_o(low_n_w[gi])
      );
    end
  endgenerate

  assign phase_a_high_out_n_o = high_n_w[0];
  assign phase_a_low_out_n_o = low_n_w[0];
  assign phase_b_high_out_n_o = high_n_w[1];
  assign phase_b_low_out_n_o = low_n_w[1];
  assign phase_c_high_out_n_o = high_n_w[2];
  assign phase_c_low_out_n_o = low_n_w[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses read zero.

  logic [31:0] rd_mux;
  logic [31:0] status_w;

  assign status_w = {28'h0000000, half_r, 1'b0, state_r == ST_RUN, armed_w};
  assign rd_mux = (adr_i == ADDR_DUTY_A) ? {16'h0000, duty_r[0]} :
                  (adr_i == ADDR_DUTY_B) ? {16'h0000, duty_r[1]} :
                  (adr_i == ADDR_DUTY_C) ? {16'h0000, duty_r[2]} :
                  (adr_i == ADDR_HALF_PERIOD) ? {16'h0000, half_period_count_r} :
                  (adr_i == ADDR_DEAD_TIME) ? {22'h000000, dead_time_count_r} :
                  (adr_i == ADDR_MIN_PULSE) ? {16'h0000, min_pulse_width_r} :
                  (adr_i == ADDR_SYNC_WIDTH) ? {24'h000000, sync_pulse_width_r} :
                  (adr_i == ADDR_MODE_CTRL) ? {16'h0000, mode_control_reg_r} :
                  (adr_i == ADDR_STATUS) ? status_w : 32'h00000000;

  // Read data is captured when the request is taken and held through ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_r <= 32'h00000000;
    else if (req_w && !ack_r) dat_r <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_request;
    req_w && !ack_r;
  endsequence

  sequence s_one_ack;
    ack_r ##1 !ack_r;
  endsequence

  property p_bus_ack;
    @(posedge clk_i) disable iff (rst_i) s_request |=> s_one_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack not a single pulse");

  property p_readback;
    @(posedge clk_i) disable iff (rst_i)
      s_request ##0 (!we_i && adr_i == ADDR_DUTY_B) |=> dat_o[15:0] == $past(duty_r[1]);
  endproperty
  a_readback: assert property (p_readback) else $error("duty read mismatch");

  property p_hold_off;
    @(posedge clk_i) disable iff (rst_i)
      !outputs_on_w |=> (&high_n_w) && (&low_n_w);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("output before armed");

  property p_latch;
    @(posedge clk_i) disable iff (rst_i)
      $rose(sync_r) |-> (act_r == $past(shadow_w)) && (duty_act_r == $past(duty_r));
  endproperty
  a_latch: assert property (p_latch) else $error("sync did not latch values");

  property p_mid_sync;
    @(posedge clk_i) disable iff (rst_i)
      $rose(half_r) && $past(double_w) && !$past(wr_half) |-> $rose(sync_r);
  endproperty
  a_mid_sync: assert property (p_mid_sync) else $error("no midpoint sync");

  property p_single_mid;
    @(posedge clk_i) disable iff (rst_i)
      $rose(half_r) && !$past(double_w) |-> !$rose(sync_r);
  endproperty
  a_single_mid: assert property (p_single_mid) else $error("midpoint sync in single");

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
      wr_half && !double_w |=> (state_r == ST_RUN) && !half_r
                               && (cnt_r == {1'b0, $past(half_nxt[15:1])});
  endproperty
  a_start: assert property (p_start) else $error("timer start position wrong");

  property p_period_sync;
    @(posedge clk_i) disable iff (rst_i)
      $rose(sync_r) && !$past(double_w) |-> !half_r && (cnt_r == ZERO_16);
  endproperty
  a_period_sync: assert property (p_period_sync) else $error("sync off period start");

endmodule // pwm_timing_unit

// file: testbench/gate_driver_model.sv
`timescale 1ns/100ps
// Gate driver stand-in: it measures how long each switch conducts between sync rises.
module gate_driver_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Switch commands and period marker.
  input wire logic [5:0] gate_n_i,
  input wire logic sync_i,
  // Measurements of the last closed window, and a leg-overlap flag that stays set until reset.
  output logic [5:0][15:0] on_time_o,
  output logic [15:0] span_o,
  output logic overlap_o
);
  logic [5:0][15:0] acc_r;
  logic [15:0] len_r;
  logic prev_r;
  wire logic rise = sync_i && !prev_r;

  ////////////////////////////////////////////////////////////////////////////////
  // A window closes at each sync rise, so its length is one update interval.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= '0;
      len_r <= 16'h0000;
      prev_r <= 1'b0;
      overlap_o <= 1'b0;
    end else begin
      prev_r <= sync_i;
      len_r <= rise ? 16'h0001 : len_r + 16'h0001;
      if (rise) begin
        on_time_o <= acc_r;
        span_o <= len_r;
      end
      for (int i = 0; i < 6; i++) begin
        acc_r[i] <= (rise ? 16'h0000 : acc_r[i]) + {15'h0000, ~gate_n_i[i]};
      end
      // Both switches of one leg on at once would short the supply.
      for (int k = 0; k < 3; k++) begin
        if (!gate_n_i[2*k] && !gate_n_i[2*k+1]) begin
          overlap_o <= 1'b1;
        end
      end
    end
  end
endmodule // gate_driver_model

// file: testbench/tb_pwm_timing_unit.sv
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end
module tb_pwm_timing_unit
  import pwm_pkg::*;
;
  // Bus drives and observed outputs.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  wire logic [31:0] dat_o;
  wire logic ack_o;
  wire logic [5:0] gate_n;
  wire logic sync;
  wire logic [5:0][15:0] on_t;
  wire logic [15:0] span;
  wire logic overlap;
  logic [31:0] rq;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Rows: dead time, minimum width, duty A, duty B, duty C; half period is 20.
  int cs [4][5] = '{'{2, 0, 8, 12, 13}, '{2, 0, 25, 0, 20}, '{3, 10, 5, 100, 14},
                    '{0, 0, 0, 20, 10}};

  always #10 clk_i = ~clk_i;

  pwm_timing_unit pwm_timing_unit_i (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o), .ack_o(ack_o),
    .phase_a_high_out_n_o(gate_n[0]), .phase_a_low_out_n_o(gate_n[1]),
    .phase_b_high_out_n_o(gate_n[2]), .phase_b_low_out_n_o(gate_n[3]),
    .phase_c_high_out_n_o(gate_n[4]), .phase_c_low_out_n_o(gate_n[5]),
    .cycle_sync_pulse_o(sync));

  gate_driver_model gate_driver_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .gate_n_i(gate_n), .sync_i(sync),
    .on_time_o(on_t), .span_o(span), .overlap_o(overlap));

  ////////////////////////////////////////////////////////////////////////////////
  // The run should end just under 1000 cycles; a hang is cut well beyond that.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Classic single cycle; the request stands until ack is sampled high.
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    dat <= {16'h0000, d};
    sel <= 4'h3;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rq = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_sync();
    logic p;
    do begin
      p = sync;
      @(posedge clk_i);
      #1;
    end while (!(sync === 1'b1 && p === 1'b0));
  endtask

  // The timer starts at the half-period write; edges are counted to the first sync.
  task automatic first_sync(input int k);
    int n;
    wb(ADDR_HALF_PERIOD, 1'b1, 16'h0014);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (sync !== 1'b1);
    `CHECK("first sync delay", k, n)
  endtask

  function automatic logic [31:0] exp_pair(input int h, input int dt, input int mn,
                                           input int d);
    int hi;
    int lo;
    hi = d - dt;
    lo = h - d - dt;
    hi = (hi < 0) ? 0 : (hi > h) ? h : hi;
    lo = (lo < 0) ? 0 : (lo > h) ? h : lo;
    if (hi < mn) begin
      hi = 0;
      lo = h;
    end else if (lo < mn) begin
      lo = 0;
      hi = h;
    end
    return {16'(2 * hi), 16'(2 * lo)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: defaults, start-up, single-mode table, double mode, restart.
  initial begin
    logic idle;
    logic hs;
    logic [31:0] ev;
    logic [15:0] sum_hi;
    logic [15:0] sum_lo;
    reset_dut();
    wb(ADDR_MODE_CTRL, 1'b0, 16'h0000);
    `CHECK("mode reset", 32'h00000000, rq)
    wb(ADDR_SYNC_WIDTH, 1'b0, 16'h0000);
    `CHECK("sync width reset", 32'h00000027, rq)
    wb(8'h24, 1'b1, 16'hFFFF);
    wb(8'h24, 1'b0, 16'h0000);
    `CHECK("unmapped read", 32'h00000000, rq)
    wb(ADDR_SYNC_WIDTH, 1'b1, 16'h0000);
    first_sync(30);
    wb(ADDR_DUTY_A, 1'b1, 16'hA5C3);
    wb(ADDR_DUTY_A, 1'b0, 16'h0000);
    `CHECK("duty readback", 32'h0000A5C3, rq)
    wb(ADDR_DUTY_B, 1'b1, 16'h0008);
    wb(ADDR_DUTY_B, 1'b0, 16'h0000);
    `CHECK("duty b readback", 32'h00000008, rq)
    idle = 1'b1;
    repeat (45) begin
      @(posedge clk_i);
      #1;
      idle &= (gate_n === 6'h3F);
    end
    `CHECK("outputs held off", 1'b1, idle)
    wb(ADDR_DUTY_C, 1'b1, 16'h0008);
    wb(ADDR_STATUS, 1'b0, 16'h0000);
    `CHECK("armed and running", 2'b11, rq[1:0])
    for (int i = 0; i < 4; i++) begin
      wb(ADDR_DEAD_TIME, 1'b1, 16'(cs[i][0]));
      wb(ADDR_MIN_PULSE, 1'b1, 16'(cs[i][1]));
      for (int p = 0; p < 3; p++) wb(ADDR_DUTY_A + 8'(4 * p), 1'b1, 16'(cs[i][2+p]));
      // The first window after the latch still holds one sample of the old set.
      repeat (4) wait_sync();
      for (int p = 0; p < 3; p++) begin
        ev = exp_pair(20, cs[i][0], cs[i][1], cs[i][2+p]);
        `CHECK("high on-time", ev[31:16], on_t[2*p])
        `CHECK("low on-time", ev[15:0], on_t[2*p+1])
      end
    end
    `CHECK("single period", 16'h0028, span)
    // Alternate duty per half so the period sum shows single-clock steps.
    wb(ADDR_MODE_CTRL, 1'b1, 16'h0040);
    wb(ADDR_DEAD_TIME, 1'b1, 16'h0002);
    wb(ADDR_MIN_PULSE, 1'b1, 16'h0000);
    hs = 1'b0;
    sum_hi = 16'h0000;
    sum_lo = 16'h0000;
    for (int j = 0; j < 8; j++) begin
      wait_sync();
      if (j >= 6) begin
        sum_hi += on_t[0];
        sum_lo += on_t[1];
      end
      wb(ADDR_STATUS, 1'b0, 16'h0000);
      if (j > 2) `CHECK("half flag", ~hs, rq[STATUS_HALF_BIT])
      hs = rq[STATUS_HALF_BIT];
      wb(ADDR_DUTY_A, 1'b1, hs ? 16'h0009 : 16'h000C);
    end
    `CHECK("double interval", 16'h0014, span)
    `CHECK("double high sum", 16'h0011, sum_hi)
    `CHECK("double low sum", 16'h000F, sum_lo)
    `CHECK("no leg overlap", 1'b0, overlap)
    reset_dut();
    wb(ADDR_SYNC_WIDTH, 1'b1, 16'h0000);
    wb(ADDR_MODE_CTRL, 1'b1, 16'h0040);
    first_sync(20);
    end_sim();
  end
endmodule // tb_pwm_timing_unit
